// file: ghs_pkg.sv
// Shared constants and types for the gauge host serial engine
// What this block does
// R1: Command byte: top bit write, low seven address
// R2: Write stores next byte; read returns eight bits
// R3: All bytes travel least significant bit first; the I2C end here shifts bytes most significant bit first
// R4: Host bit rate stays at or below 5 kbit/s
// R5: Long low is break; ready after recovery high
// R6: Host breaks first and after any response timeout
// R7: Bit: start low, data value, high to cycle
// R8: Unlimited idle high between received bits
// R9: Read answer waits response delay, device bit timing
// R10: Open-drain line; parties only pull low
// R11: Host breaks before communications after insertion bounce
// R12: Host reads sixteen bits high, low, high
// R13: Reported values update at most every 1.28 s
// R14: I2C slave answers only address 1010101
// R15: Write, quick read, read, incremental read supported
// R16: Pointer advances after every data byte; the I2C end here holds it after a NACKed write byte
// R17: Even read latches odd byte, pointer plus two
// R18: Odd byte sent only after ack, no stop
// R19: Write to read-only address gets NACK
// R20: Command above 0x7F gets NACK
// R21: Data bytes after first write byte get NACK
// R22: Bus stuck low releases lines, may sleep
// R23: Lines low 18 s, quiet: sleep until high
// R24: Break drops partial bytes, receiver back idle
package ghs_pkg;
  localparam int CLK_MHZ = 200;
  // Link timings in microseconds; bus stuck, update and sleep in ms and s
  localparam int T_BREAK_MIN_US = 190;
  localparam int T_HOST_BREAK_US = 250;
  localparam int T_BREAK_RECOVERY_TIME_US = 40;
  localparam int T_HOST_RECOVERY_US = 60;
  localparam int T_HOST_START_LOW_TIME_US = 50;
  localparam int T_HOST_DATA_VALID_TIME_US = 100;
  localparam int T_HOST_BIT_CYCLE_TIME_US = 200; // 5 kbit/s ceiling
  localparam int T_DEVICE_START_LOW_TIME_US = 40;
  localparam int T_DEVICE_DATA_VALID_TIME_US = 100;
  localparam int T_DEVICE_BIT_CYCLE_TIME_US = 190;
  localparam int T_READ_RESPONSE_DELAY_US = 190;
  localparam int T_HOST_WAIT_US = 320;
  localparam int T_DEV_ONE_MAX_US = 75;
  localparam int T_HOST_ONE_MAX_US = 70;
  localparam int T_BUS_STUCK_TIMEOUT_MS = 2;
  localparam int T_UPDATE_MS = 1280;
  localparam int T_SLEEP_S = 18;
  // Cycle counts at the core clock
  localparam logic [31:0] C_BREAK_MIN = 32'(T_BREAK_MIN_US * CLK_MHZ);
  localparam logic [31:0] C_HOST_BREAK = 32'(T_HOST_BREAK_US * CLK_MHZ);
  localparam logic [31:0] C_BREAK_RECOVERY = 32'(T_BREAK_RECOVERY_TIME_US * CLK_MHZ);
  localparam logic [31:0] C_HOST_RECOVERY = 32'(T_HOST_RECOVERY_US * CLK_MHZ);
  localparam logic [31:0] C_HOST_START = 32'(T_HOST_START_LOW_TIME_US * CLK_MHZ);
  localparam logic [31:0] C_HOST_DATA = 32'(T_HOST_DATA_VALID_TIME_US * CLK_MHZ);
  localparam logic [31:0] C_HOST_CYCLE = 32'(T_HOST_BIT_CYCLE_TIME_US * CLK_MHZ);
  localparam logic [31:0] C_DEV_START = 32'(T_DEVICE_START_LOW_TIME_US * CLK_MHZ);
  localparam logic [31:0] C_DEV_DATA = 32'(T_DEVICE_DATA_VALID_TIME_US * CLK_MHZ);
  localparam logic [31:0] C_DEV_CYCLE = 32'(T_DEVICE_BIT_CYCLE_TIME_US * CLK_MHZ);
  localparam logic [31:0] C_RESPONSE = 32'(T_READ_RESPONSE_DELAY_US * CLK_MHZ);
  localparam logic [31:0] C_HOST_WAIT = 32'(T_HOST_WAIT_US * CLK_MHZ);
  localparam logic [31:0] C_DEV_ONE_MAX = 32'(T_DEV_ONE_MAX_US * CLK_MHZ);
  localparam logic [31:0] C_HOST_ONE_MAX = 32'(T_HOST_ONE_MAX_US * CLK_MHZ);
  localparam logic [31:0] C_BUS_STUCK = 32'(T_BUS_STUCK_TIMEOUT_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] C_UPDATE = 32'(T_UPDATE_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] C_SLEEP = 32'(64'(T_SLEEP_S) * 64'd1000000 * 64'(CLK_MHZ));
  // Register space and framing
  localparam int REG_COUNT = 128;
  localparam logic [6:0] WRITABLE_LO = 7'h60;
  localparam logic [6:0] I2C_SLAVE_ADDR = 7'h55;
  localparam int CMD_WRITE_BIT = 7;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [3:0] BC_ACK = 4'h8;
  localparam logic [3:0] BC_END = 4'hA;
  localparam logic [6:0] PTR_PAIR_STEP = 7'h2;
  localparam logic [3:0] SYNC_IDLE = 4'h7;
  typedef enum logic [1:0] {GHS_OP_BREAK, GHS_OP_WRITE, GHS_OP_READ, GHS_OP_READ16} ghs_op_e;
endpackage

// file: ghs_if.sv
// Link wires between host and device ends
`timescale 1ns/10ps
`default_nettype none
interface ghs_if;
  logic ow_host_oe;
  logic ow_dev_oe;
  logic scl_host_oe;
  logic scl_dev_oe;
  logic sda_host_oe;
  logic sda_dev_oe;
  wire logic ow_line;
  wire logic scl;
  wire logic sda;
  // Open-drain wired-AND with pull-up
  assign ow_line = ~(ow_host_oe | ow_dev_oe);
  assign scl = ~(scl_host_oe | scl_dev_oe);
  assign sda = ~(sda_host_oe | sda_dev_oe);
  modport dev (input ow_line, input scl, input sda,
               output ow_dev_oe, output scl_dev_oe, output sda_dev_oe);
  modport host (input ow_line, output ow_host_oe);
endinterface
`default_nettype wire

// file: ghs_dev.sv
// Device end: one-wire and I2C register-access slave
`timescale 1ns/10ps
`default_nettype none
module ghs_dev
  import ghs_pkg::*;
#(
  parameter logic [31:0] P_BREAK = C_BREAK_MIN,
  parameter logic [31:0] P_RECOVERY = C_BREAK_RECOVERY,
  parameter logic [31:0] P_RESPONSE = C_RESPONSE,
  parameter logic [31:0] P_START = C_DEV_START,
  parameter logic [31:0] P_DATA = C_DEV_DATA,
  parameter logic [31:0] P_CYCLE = C_DEV_CYCLE,
  parameter logic [31:0] P_ONE_MAX = C_DEV_ONE_MAX,
  parameter logic [31:0] P_BUS_STUCK = C_BUS_STUCK,
  parameter logic [31:0] P_SLEEP = C_SLEEP,
  parameter logic [31:0] P_UPDATE = C_UPDATE
) (
  ghs_if.dev lnk,
  input wire logic clk,
  input wire logic rst_b,
  input wire logic variant_i2c,
  input wire logic activity_low,
  input wire logic upd_valid,
  input wire logic upd_last,
  input wire logic [6:0] upd_addr,
  input wire logic [7:0] upd_data,
  output logic upd_ready_r,
  output logic sleep_r
);
  typedef enum logic [2:0] {O_IDLE, O_LOW, O_BRK, O_REC, O_RSP, O_TX} ghs_ow_e;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_CMD, I_WDAT, I_RDAT} ghs_i2c_e;

  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic [7:0] mem_r [REG_COUNT];
  logic [31:0] upd_cnt_r;
  logic [31:0] lo_cnt_r;
  ghs_ow_e ow_st_r;
  logic [31:0] ow_cnt_r;
  logic [7:0] ow_sh_r;
  logic [2:0] ow_n_r;
  logic ow_have_cmd_r;
  logic [7:0] ow_cmd_r;
  logic ow_oe_r;
  ghs_i2c_e i_st_r;
  logic [3:0] i_bc_r;
  logic [7:0] i_sh_r;
  logic [6:0] i_ptr_r;
  logic i_ack_r;
  logic i_mack_r;
  logic i_first_r;
  logic i_odd_r;
  logic [7:0] i_hold_r;
  logic sda_oe_r;

  // Two-flop synchronisers, third stage only for edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= SYNC_IDLE;
      s2_r <= SYNC_IDLE;
      s3_r <= SYNC_IDLE;
    end else begin
      s1_r <= {variant_i2c, lnk.sda, lnk.scl, lnk.ow_line};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Line decoding
  wire logic ow = s2_r[0];
  wire logic scl = s2_r[1];
  wire logic sda = s2_r[2];
  wire logic i2c_mode = s2_r[3];
  wire logic ow_fall = s3_r[0] & ~ow;
  wire logic ow_rise = ~s3_r[0] & ow;
  wire logic scl_rise = ~s3_r[1] & scl;
  wire logic scl_fall = s3_r[1] & ~scl;
  wire logic i2c_start = scl & s3_r[1] & s3_r[2] & ~sda;
  wire logic i2c_stop = scl & s3_r[1] & ~s3_r[2] & sda;
  wire logic any_low = i2c_mode ? ~(scl & sda) : ~ow;
  wire logic bus_stuck = i2c_mode & (lo_cnt_r == P_BUS_STUCK); // R22

  // One-wire decoding: short low is a one
  wire logic ow_bit = ow_cnt_r < P_ONE_MAX; // R7
  wire logic [7:0] ow_byte = {ow_bit, ow_sh_r[7:1]}; // R3
  wire logic ow_done = (ow_st_r == O_LOW) & ow_rise & (ow_n_r == BYTE_LAST);
  wire logic ow_we = ~i2c_mode & ow_done & ow_have_cmd_r & (ow_cmd_r[6:0] >= WRITABLE_LO); // R2
  wire logic ow_tx_oe = (ow_cnt_r < P_START) | ((ow_cnt_r < P_DATA) & ~ow_sh_r[0]); // R7 R9

  // I2C decoding
  wire logic i_tx = i_st_r == I_RDAT;
  wire logic [7:0] tx_byte = i_odd_r ? i_hold_r : mem_r[i_ptr_r]; // R18
  wire logic ack_addr = (i_st_r == I_ADDR) & (i_sh_r[7:1] == I2C_SLAVE_ADDR); // R14
  wire logic ack_cmd = (i_st_r == I_CMD) & ~i_sh_r[CMD_WRITE_BIT]; // R20
  wire logic ack_wr = (i_st_r == I_WDAT) & i_first_r & (i_ptr_r >= WRITABLE_LO); // R19 R21
  wire logic ack_ok = ack_addr | ack_cmd | ack_wr;
  wire logic i_end = scl_fall & (i_bc_r == BC_END);
  wire logic i_load = i_end & (((i_st_r == I_ADDR) & i_ack_r & i_sh_r[0]) | (i_tx & i_mack_r));
  wire logic i_we = i2c_mode & ~bus_stuck & scl_fall & (i_bc_r == BC_ACK) & ack_wr;

  // Bus write port, modes are exclusive
  wire logic bus_we = ow_we | i_we;
  wire logic [6:0] bus_wa = i2c_mode ? i_ptr_r : ow_cmd_r[6:0];
  wire logic [7:0] bus_wd = i2c_mode ? i_sh_r : ow_byte;
  wire logic upd_take = upd_valid & upd_ready_r;

  // Register array; a bus write wins an address collision
  always_ff @(posedge clk) begin
    if (upd_take) begin
      mem_r[upd_addr] <= upd_data;
    end
    if (bus_we) begin
      mem_r[bus_wa] <= bus_wd;
    end
  end

  // Update window opens once per period, closes on last byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      upd_cnt_r <= '0;
      upd_ready_r <= 1'b0;
    end else if (upd_take & upd_last) begin
      upd_cnt_r <= '0;
      upd_ready_r <= 1'b0; // R13
    end else if (upd_cnt_r >= P_UPDATE) begin
      upd_ready_r <= 1'b1;
    end else begin
      upd_cnt_r <= upd_cnt_r + 32'h1;
    end
  end

  // Low-line timer, saturating; sleep until every line is high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lo_cnt_r <= '0;
      sleep_r <= 1'b0;
    end else begin
      if (!any_low) begin
        lo_cnt_r <= '0;
        sleep_r <= 1'b0; // R23
      end else if (lo_cnt_r < P_SLEEP) begin
        lo_cnt_r <= lo_cnt_r + 32'h1;
      end else if (activity_low) begin
        sleep_r <= 1'b1; // R22 R23
      end
    end
  end

  // One-wire engine; own transmit edges are ignored while sending
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ow_st_r <= O_BRK;
      ow_cnt_r <= '0;
      ow_sh_r <= '0;
      ow_n_r <= '0;
      ow_have_cmd_r <= 1'b0;
      ow_cmd_r <= '0;
      ow_oe_r <= 1'b0;
    end else if (i2c_mode) begin
      ow_st_r <= O_BRK;
      ow_oe_r <= 1'b0;
    end else begin
      ow_cnt_r <= ow_cnt_r + 32'h1;
      unique case (ow_st_r)
        O_IDLE: begin
          ow_cnt_r <= '0;
          if (ow_fall) begin
            ow_st_r <= O_LOW; // R8
          end
        end
        O_LOW: begin
          if (ow_rise) begin
            ow_sh_r <= ow_byte;
            ow_n_r <= ow_n_r + 3'h1;
            ow_st_r <= O_IDLE;
            if (ow_done & ~ow_have_cmd_r) begin
              ow_cmd_r <= ow_byte; // R1
              ow_have_cmd_r <= ow_byte[CMD_WRITE_BIT];
              if (!ow_byte[CMD_WRITE_BIT]) begin
                ow_st_r <= O_RSP;
                ow_cnt_r <= '0;
              end
            end else if (ow_done) begin
              ow_have_cmd_r <= 1'b0;
            end
          end else if (ow_cnt_r >= P_BREAK) begin
            ow_st_r <= O_BRK; // R5
            ow_n_r <= '0; // R24
            ow_have_cmd_r <= 1'b0; // R24
          end
        end
        O_BRK: begin
          ow_cnt_r <= '0;
          if (ow) begin
            ow_st_r <= O_REC;
          end
        end
        O_REC: begin
          if (!ow) begin
            ow_st_r <= O_BRK;
          end else if (ow_cnt_r >= P_RECOVERY) begin
            ow_st_r <= O_IDLE; // R5
          end
        end
        O_RSP: begin
          if (ow_cnt_r >= P_RESPONSE) begin
            ow_st_r <= O_TX; // R9
            ow_cnt_r <= '0;
            ow_sh_r <= mem_r[ow_cmd_r[6:0]]; // R2
            ow_n_r <= '0;
          end
        end
        O_TX: begin
          ow_oe_r <= ow_tx_oe; // R10
          if (ow_cnt_r >= P_CYCLE) begin
            ow_cnt_r <= '0;
            ow_oe_r <= 1'b0;
            ow_sh_r <= {1'b0, ow_sh_r[7:1]}; // R3
            ow_n_r <= ow_n_r + 3'h1;
            if (ow_n_r == BYTE_LAST) begin
              ow_st_r <= O_IDLE;
            end
          end
        end
        default: ow_st_r <= O_BRK;
      endcase
    end
  end

  // I2C engine: sample on SCL rise, drive on SCL fall
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      i_st_r <= I_IDLE;
      i_bc_r <= '0;
      i_sh_r <= '0;
      i_ptr_r <= '0;
      i_ack_r <= 1'b0;
      i_mack_r <= 1'b0;
      i_first_r <= 1'b0;
      i_odd_r <= 1'b0;
      i_hold_r <= '0;
      sda_oe_r <= 1'b0;
    end else if (!i2c_mode || bus_stuck) begin
      i_st_r <= I_IDLE; // R22
      sda_oe_r <= 1'b0;
      i_odd_r <= 1'b0;
    end else if (i2c_start) begin
      i_st_r <= I_ADDR; // R15
      i_bc_r <= '0;
      sda_oe_r <= 1'b0;
      i_odd_r <= 1'b0; // R18
    end else if (i2c_stop) begin
      i_st_r <= I_IDLE;
      sda_oe_r <= 1'b0;
      i_odd_r <= 1'b0; // R18
    end else if (i_st_r != I_IDLE) begin
      if (scl_rise) begin
        i_bc_r <= i_bc_r + 4'h1;
        if (i_bc_r < BC_ACK) begin
          i_sh_r <= {i_sh_r[6:0], sda};
        end else begin
          i_mack_r <= ~sda;
        end
      end
      if (scl_fall && i_bc_r == BC_ACK) begin
        i_bc_r <= i_bc_r + 4'h1;
        i_ack_r <= ack_ok;
        sda_oe_r <= ack_ok; // R19 R20 R21
      end else if (i_end) begin
        i_bc_r <= '0;
        sda_oe_r <= 1'b0;
        unique case (i_st_r)
          I_ADDR: i_st_r <= !i_ack_r ? I_IDLE : (i_sh_r[0] ? I_RDAT : I_CMD);
          I_CMD: begin
            i_st_r <= i_ack_r ? I_WDAT : I_IDLE;
            i_ptr_r <= i_sh_r[6:0];
            i_first_r <= 1'b1;
          end
          I_WDAT: begin
            i_first_r <= 1'b0; // R21
            if (i_ack_r) begin
              i_ptr_r <= i_ptr_r + 7'h1; // R16
            end
          end
          I_RDAT: begin
            if (!i_mack_r) begin
              i_st_r <= I_IDLE;
            end
          end
          default: i_st_r <= I_IDLE;
        endcase
        if (i_load) begin
          i_sh_r <= tx_byte;
          sda_oe_r <= ~tx_byte[7];
          if (i_odd_r) begin
            i_odd_r <= 1'b0; // R18
          end else if (!i_ptr_r[0]) begin
            i_hold_r <= mem_r[i_ptr_r | 7'h1]; // R17
            i_odd_r <= 1'b1;
            i_ptr_r <= i_ptr_r + PTR_PAIR_STEP; // R17
          end else begin
            i_ptr_r <= i_ptr_r + 7'h1; // R16
          end
        end
      end else if (scl_fall && i_tx && i_bc_r != '0 && i_bc_r < BC_ACK) begin
        sda_oe_r <= ~i_sh_r[7];
      end
    end
  end

  // Line drives; no clock stretching
  assign lnk.ow_dev_oe = ow_oe_r;
  assign lnk.sda_dev_oe = sda_oe_r;
  assign lnk.scl_dev_oe = 1'b0;
endmodule
`default_nettype wire

// file: ghs_host.sv
// Host end: one-wire bus master with break and sixteen-bit reads
`timescale 1ns/10ps
`default_nettype none
module ghs_host
  import ghs_pkg::*;
#(
  parameter logic [31:0] P_BREAK = C_HOST_BREAK,
  parameter logic [31:0] P_RECOVERY = C_HOST_RECOVERY,
  parameter logic [31:0] P_START = C_HOST_START,
  parameter logic [31:0] P_DATA = C_HOST_DATA,
  parameter logic [31:0] P_CYCLE = C_HOST_CYCLE,
  parameter logic [31:0] P_WAIT = C_HOST_WAIT,
  parameter logic [31:0] P_ONE_MAX = C_HOST_ONE_MAX
) (
  ghs_if.host lnk,
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire ghs_op_e cmd_op,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic busy_r,
  output logic done_r,
  output logic timeout_r,
  output logic [15:0] rdata_r
);
  typedef enum logic [2:0] {H_IDLE, H_BRK, H_BRW, H_SEQ, H_TX, H_RXW, H_RXL, H_RXE} ghs_hst_e;

  ghs_hst_e st_r;
  logic [1:0] s_r;
  logic s3_r;
  logic [31:0] cnt_r;
  logic [7:0] sh_r;
  logic [2:0] n_r;
  logic [2:0] seq_r;
  logic need_brk_r;
  logic oe_r;
  ghs_op_e op_r;
  logic [6:0] addr_r;
  logic [7:0] wd_r;
  logic [7:0] rxb_r [4];

  // Line synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= 2'h3;
      s3_r <= 1'b1;
    end else begin
      s_r <= {s_r[0], lnk.ow_line};
      s3_r <= s_r[1];
    end
  end

  // Sequencing of bytes per operation
  wire logic ow = s_r[1];
  wire logic ow_fall = s3_r & ~ow;
  wire logic ow_rise = ~s3_r & ow;
  wire logic is_wr = op_r == GHS_OP_WRITE;
  wire logic is_r16 = op_r == GHS_OP_READ16;
  wire logic [6:0] rd_addr = (is_r16 & ~seq_r[0]) ? addr_r + 7'h1 : addr_r; // R12
  wire logic [7:0] tx_byte = (is_wr & seq_r[0]) ? wd_r : {is_wr, is_wr ? addr_r : rd_addr}; // R1
  wire logic hi_match = rxb_r[2] == rxb_r[0];
  wire logic fin = is_wr ? (seq_r == 3'h2) : is_r16 ? ((seq_r == 3'h3 & hi_match) | seq_r == 3'h4)
                   : (seq_r == 3'h1);
  wire logic [15:0] result = !is_r16 ? {8'h00, rxb_r[0]} :
                             (seq_r == 3'h3) ? {rxb_r[0], rxb_r[1]} : {rxb_r[2], rxb_r[3]}; // R12
  wire logic tx_oe = (cnt_r < P_START) | ((cnt_r < P_DATA) & ~sh_r[0]); // R7
  wire logic rx_bit = cnt_r < P_ONE_MAX;

  // Master engine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= H_IDLE;
      cnt_r <= '0;
      sh_r <= '0;
      n_r <= '0;
      seq_r <= '0;
      need_brk_r <= 1'b1; // R6
      oe_r <= 1'b0;
      op_r <= GHS_OP_BREAK;
      addr_r <= '0;
      wd_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      timeout_r <= 1'b0;
      rdata_r <= '0;
      for (int i = 0; i < 4; i++) begin
        rxb_r[i] <= '0;
      end
    end else begin
      done_r <= 1'b0;
      timeout_r <= 1'b0;
      cnt_r <= cnt_r + 32'h1;
      unique case (st_r)
        H_IDLE: begin
          cnt_r <= '0;
          if (cmd_valid) begin
            op_r <= cmd_op;
            addr_r <= cmd_addr;
            wd_r <= cmd_wdata;
            seq_r <= '0;
            busy_r <= 1'b1;
            st_r <= (cmd_op == GHS_OP_BREAK || need_brk_r) ? H_BRK : H_SEQ; // R6 R11
          end
        end
        H_BRK: begin
          oe_r <= 1'b1;
          if (cnt_r >= P_BREAK) begin
            oe_r <= 1'b0;
            cnt_r <= '0;
            st_r <= H_BRW;
          end
        end
        H_BRW: begin
          if (cnt_r >= P_RECOVERY) begin
            need_brk_r <= 1'b0;
            st_r <= (op_r == GHS_OP_BREAK) ? H_SEQ : H_SEQ;
            if (op_r == GHS_OP_BREAK) begin
              st_r <= H_IDLE;
              busy_r <= 1'b0;
              done_r <= 1'b1;
            end
          end
        end
        H_SEQ: begin
          cnt_r <= '0;
          n_r <= '0;
          if (fin) begin
            st_r <= H_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b1;
            rdata_r <= result;
          end else begin
            sh_r <= tx_byte;
            st_r <= H_TX;
          end
        end
        H_TX: begin
          oe_r <= tx_oe; // R10
          if (cnt_r >= P_CYCLE) begin
            oe_r <= 1'b0;
            cnt_r <= '0; // R4
            sh_r <= {1'b0, sh_r[7:1]}; // R3
            n_r <= n_r + 3'h1;
            if (n_r == BYTE_LAST) begin
              st_r <= is_wr ? H_SEQ : H_RXW;
              seq_r <= is_wr ? seq_r + 3'h1 : seq_r;
            end
          end
        end
        H_RXW: begin
          if (ow_fall) begin
            cnt_r <= '0;
            st_r <= H_RXL;
          end else if (cnt_r >= P_WAIT) begin
            need_brk_r <= 1'b1; // R6
            timeout_r <= 1'b1;
            done_r <= 1'b1;
            busy_r <= 1'b0;
            st_r <= H_IDLE;
          end
        end
        H_RXL: begin
          if (ow_rise) begin
            cnt_r <= '0;
            sh_r <= {rx_bit, sh_r[7:1]}; // R3
            n_r <= n_r + 3'h1;
            st_r <= H_RXW;
            if (n_r == BYTE_LAST) begin
              rxb_r[seq_r[1:0]] <= {rx_bit, sh_r[7:1]};
              seq_r <= seq_r + 3'h1;
              st_r <= H_RXE;
            end
          end
        end
        // Device ignores the line until its last bit cycle ends
        H_RXE: begin
          if (cnt_r >= P_CYCLE) begin
            st_r <= H_SEQ; // R9
          end
        end
      endcase
    end
  end

  assign lnk.ow_host_oe = oe_r;
endmodule
`default_nettype wire

// file: ghs_checker.sv
// Concurrent checks on the one-wire link between host and device ends
`timescale 1ns/10ps
`default_nettype none
module ghs_checker #(
  parameter logic [31:0] P_RESPONSE = 32'h190,
  parameter logic [31:0] P_START = 32'h3C,
  parameter logic [31:0] P_DATA = 32'hA0,
  parameter logic [31:0] P_CYCLE = 32'h12C,
  parameter logic [31:0] P_ONE_MAX = 32'h6E
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ow_host_oe,
  input wire logic ow_dev_oe,
  input wire logic scl_dev_oe,
  input wire logic sda_dev_oe
);
  logic dq_r;
  logic [31:0] hst_r;
  logic [31:0] gap_r;
  logic [31:0] low_r;
  logic [3:0] bits_r;
  wire logic rise = ow_dev_oe & ~dq_r;
  // Quiet time after host, reply spacing, pulse width, reply bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dq_r <= 1'b0;
      hst_r <= '1;
      gap_r <= '1;
      low_r <= '0;
      bits_r <= '0;
    end else begin
      dq_r <= ow_dev_oe;
      hst_r <= ow_host_oe ? '0 : hst_r + {31'h0, ~&hst_r};
      gap_r <= rise ? 32'h1 : gap_r + {31'h0, ~&gap_r};
      low_r <= ow_dev_oe ? low_r + 32'h1 : '0;
      bits_r <= ow_host_oe ? '0 : bits_r + {3'h0, rise};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Start section of a reply bit spans several cycles
  sequence s_start_low; ow_dev_oe [*8]; endsequence
  property p_noclash; ow_host_oe |-> !ow_dev_oe; endproperty
  property p_resp; rise |-> hst_r >= P_RESPONSE; endproperty
  property p_gap; rise |-> gap_r >= P_CYCLE; endproperty
  property p_bits; rise |-> bits_r < 4'h8; endproperty
  property p_start; rise |-> s_start_low; endproperty
  // Margin of one cycle on the low widths
  property p_dlow; $fell(ow_dev_oe) |-> (low_r >= P_START - 32'h1 && low_r < P_ONE_MAX)
    || (low_r >= P_DATA - 32'h1 && low_r < P_CYCLE); endproperty
  property p_nosda; !sda_dev_oe; endproperty
  property p_noscl; !scl_dev_oe; endproperty
  a_noclash: assert property (p_noclash) else $error("reply overlaps host pulse");
  a_resp: assert property (p_resp) else $error("reply too early");
  a_gap: assert property (p_gap) else $error("reply bits too close");
  a_bits: assert property (p_bits) else $error("reply longer than a byte");
  a_start: assert property (p_start) else $error("start section short");
  a_dlow: assert property (p_dlow) else $error("reply low width wrong");
  a_nosda: assert property (p_nosda) else $error("data line driven");
  a_noscl: assert property (p_noscl) else $error("clock stretched");
endmodule
`default_nettype wire

// file: tb.sv
// Bench: host and device over one-wire, I2C device driven by the bench
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %h want %h", $time, a, b); end end
module tb
  import ghs_pkg::*;
;
  // I2C steps: kind 0 pin walk, 1 write byte, 2 read byte; low nibble NACK
  localparam logic [15:0] SEQ [39] = '{
    16'h04B0, 16'h1AA0, 16'h1700, 16'h1C30, 16'h1111, 16'h0E00,
    16'h04B0, 16'h1AA0, 16'h1710, 16'h1960, 16'h0E00, 16'h04B0, 16'h1441, 16'h0E00,
    16'h04B0, 16'h1AA0, 16'h1801, 16'h0E00,
    16'h04B0, 16'h1AA0, 16'h1100, 16'h1FF1, 16'h0E00,
    16'h04B0, 16'h1AA0, 16'h1100, 16'h0E00, 16'h04B0, 16'h1AB0, 16'h23C1, 16'h0E00,
    16'h04B0, 16'h1AA0, 16'h1700, 16'h04B0, 16'h1AB0, 16'h2C30, 16'h2961, 16'h0E00};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  ghs_op_e cmd_op = GHS_OP_BREAK;
  logic [6:0] cmd_addr = '0, upd_addr = '0;
  logic [7:0] cmd_wdata = '0, upd_data = '0;
  logic busy_r, done_r, timeout_r, act = 1'b0, upd_valid = 1'b0, upd_last = 1'b0;
  logic [15:0] rdata_r, r, s, seed = 16'hB312;
  logic [1:0] rdy, slp;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  logic [8:0] rx;
  int i, n_errors = 0, checks_done = 0;
  ghs_if lk[2] ();
  // 200 MHz core clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Shortened timings in cycles: host, then device and checker
  localparam logic [31:0] HT [7] = '{32'h258, 32'h96, 32'h50, 32'hA0, 32'h140, 32'h4B0,
    32'h64};
  localparam logic [31:0] DT [10] = '{32'h190, 32'h64, 32'h190, 32'h3C, 32'hA0, 32'h12C, 32'h6E,
    32'hBB8, 32'h1388, 32'h7D0};
  ghs_host #(.P_BREAK(HT[0]), .P_RECOVERY(HT[1]), .P_START(HT[2]), .P_DATA(HT[3]),
    .P_CYCLE(HT[4]), .P_WAIT(HT[5]), .P_ONE_MAX(HT[6])) ghs_host_inst (.lnk(lk[0].host),
    .clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .busy_r(busy_r), .done_r(done_r), .timeout_r(timeout_r),
    .rdata_r(rdata_r));
  // Device 0 speaks one-wire to the host, device 1 is the I2C slave
  for (genvar g = 0; g < 2; g++) begin : gd
    ghs_dev #(.P_BREAK(DT[0]), .P_RECOVERY(DT[1]), .P_RESPONSE(DT[2]), .P_START(DT[3]),
      .P_DATA(DT[4]), .P_CYCLE(DT[5]), .P_ONE_MAX(DT[6]), .P_BUS_STUCK(DT[7]),
      .P_SLEEP(DT[8]), .P_UPDATE(DT[9])) ghs_dev_inst (.lnk(lk[g].dev), .clk(clk),
      .rst_b(rst_b), .variant_i2c(1'(g)), .activity_low(act), .upd_valid(upd_valid),
      .upd_last(upd_last), .upd_addr(upd_addr), .upd_data(upd_data), .upd_ready_r(rdy[g]),
      .sleep_r(slp[g]));
  end
  ghs_checker #(.P_RESPONSE(DT[2]), .P_START(DT[3]), .P_DATA(DT[4]), .P_CYCLE(DT[5]),
    .P_ONE_MAX(DT[6])) ghs_checker_inst (.clk(clk), .rst_b(rst_b),
    .ow_host_oe(lk[0].ow_host_oe), .ow_dev_oe(lk[0].ow_dev_oe),
    .scl_dev_oe(lk[0].scl_dev_oe), .sda_dev_oe(lk[0].sda_dev_oe));
  function logic [15:0] rnd();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction
  // Inputs always move 1 ns after an edge
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    conclude();
  endtask
  // Host command: note the result, then wait for done under a bound
  task automatic cmd(input ghs_op_e op, input logic [6:0] a, input logic [7:0] d,
    input logic [17:0] x);
    exp_q.push_back(x);
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    w(1);
    cmd_valid = 1'b0;
    for (i = 0; i < 40000 && done_r !== 1'b1; i++) w(1);
    if (i == 40000) hang();
    w(1);
  endtask
  // I2C pins, 1 pulls low; byte data only moves while the clock is low
  task automatic pins(input logic d, input logic c);
    lk[1].sda_host_oe = d;
    lk[1].scl_host_oe = c;
    w(10);
  endtask
  task automatic xfer(input logic [8:0] t);
    for (int k = 8; k >= 0; k--) begin
      pins(~t[k], 1'b1);
      pins(~t[k], 1'b0);
      rx[k] = lk[1].sda;
      pins(~t[k], 1'b1);
    end
  endtask
  // Oldest note against each finished host command
  always @(posedge clk) begin
    if (done_r === 1'b1) begin
      e = exp_q.pop_front();
      `CHK(timeout_r, e[16])
      if (e[17]) `CHK(rdata_r, e[15:0])
    end
  end
  initial begin
    lk[0].scl_host_oe = 1'b0;
    lk[0].sda_host_oe = 1'b0;
    lk[1].ow_host_oe = 1'b0;
    lk[1].scl_host_oe = 1'b0;
    lk[1].sda_host_oe = 1'b0;
    w(20);
    rst_b = 1'b1;
    for (i = 0; i < 3000 && rdy !== 2'b11; i++) w(1);
    if (i == 3000) hang();
    `CHK(i > 1900, 1'b1)
    upd_valid = 1'b1;
    upd_last = 1'b1;
    upd_addr = 7'h10;
    upd_data = 8'h3C;
    w(1);
    upd_valid = 1'b0;
    w(1);
    `CHK(rdy, 2'b00)
    cmd(GHS_OP_BREAK, 7'h00, 8'h00, 18'h0);
    cmd(GHS_OP_WRITE, 7'h65, 8'hA5, 18'h0);
    cmd(GHS_OP_WRITE, 7'h64, 8'h5A, 18'h0);
    cmd(GHS_OP_READ16, 7'h64, 8'h00, {2'b10, 16'hA55A});
    cmd(GHS_OP_WRITE, 7'h10, 8'hFF, 18'h0);
    cmd(GHS_OP_READ, 7'h10, 8'h00, {2'b10, 16'h003C});
    for (int j = 0; j < 3; j++) begin
      r = rnd();
      cmd(GHS_OP_WRITE, {2'b11, r[4:0]}, r[15:8], 18'h0);
      cmd(GHS_OP_READ, {2'b11, r[4:0]}, 8'h00, {10'h200, r[15:8]});
    end
    foreach (SEQ[j]) begin
      s = SEQ[j];
      if (s[15:12] == 4'h0) begin
        for (int k = 3; k >= 0; k--) pins(s[2*k+5], s[2*k+4]);
      end else begin
        xfer(s[12] ? {s[11:4], 1'b1} : {8'hFF, s[0]});
        if (s[12]) `CHK(rx[0], s[0])
        else `CHK(rx[8:1], s[11:4])
      end
    end
    // Clock line held low with a quiet cell puts the I2C end to sleep
    act = 1'b1;
    lk[1].scl_host_oe = 1'b1;
    w(4900);
    `CHK(slp, 2'b00)
    for (i = 0; i < 400 && slp[1] !== 1'b1; i++) w(1);
    if (i == 400) hang();
    `CHK(slp, 2'b10)
    lk[1].scl_host_oe = 1'b0;
    w(8);
    `CHK(slp, 2'b00)
    conclude();
  end
endmodule
`default_nettype wire
